// ### shared/pcc_pkg.sv
// Constants shared by the per-core counter unit and its PLL tap model
package pcc_pkg;
   // Counters per core
   localparam int PCC_UNITS = 2;
   localparam int PCC_PINS = 32;

   // Register selector on the core write and read ports
   localparam logic [1:0] PCC_SEL_CTRL = 2'h0;
   localparam logic [1:0] PCC_SEL_INCR = 2'h1;
   localparam logic [1:0] PCC_SEL_PHASE = 2'h2;

   // Control register field positions
   localparam int PCC_MODE_LSB = 26;
   localparam int PCC_MODE_W = 5;
   localparam int PCC_TAP_LSB = 23;
   localparam int PCC_TAP_W = 3;
   localparam int PCC_SECONDARY_PIN_SELECT_LSB = 9;
   localparam int PCC_PRIMARY_PIN_SELECT_LSB = 0;
   localparam int PCC_PIN_W = 5;

   // Reset values
   localparam logic [31:0] PCC_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] PCC_INCR_RST = 32'h0000_0000;
   localparam logic [31:0] PCC_PHASE_RST = 32'h0000_0000;

   // Operating mode codes; codes with the top bit set are logic modes
   localparam logic [4:0] PCC_M_OFF = 5'h00;
   localparam logic [4:0] PCC_M_PLL_INT = 5'h01;
   localparam logic [4:0] PCC_M_PLL_SE = 5'h02;
   localparam logic [4:0] PCC_M_PLL_DIFF = 5'h03;
   localparam logic [4:0] PCC_M_NCO_SE = 5'h04;
   localparam logic [4:0] PCC_M_NCO_DIFF = 5'h05;
   localparam logic [4:0] PCC_M_DUTY_SE = 5'h06;
   localparam logic [4:0] PCC_M_DUTY_DIFF = 5'h07;
   localparam logic [4:0] PCC_M_POS = 5'h08;
   localparam logic [4:0] PCC_M_POS_FB = 5'h09;
   localparam logic [4:0] PCC_M_POSEDGE = 5'h0A;
   localparam logic [4:0] PCC_M_POSEDGE_FB = 5'h0B;
   localparam logic [4:0] PCC_M_NEG = 5'h0C;
   localparam logic [4:0] PCC_M_NEG_FB = 5'h0D;
   localparam logic [4:0] PCC_M_NEGEDGE = 5'h0E;
   localparam logic [4:0] PCC_M_NEGEDGE_FB = 5'h0F;

   // PLL model: VCO runs at 16x the reference, taps divide by 128 down to 1
   localparam int PCC_VCO_MULT_LOG2 = 4;
   localparam int PCC_WRAP_W = 3;
endpackage

// ### design/pcc_pll_tap.sv
// PLL model: extends the phase word and picks the divided VCO tap
`timescale 1ns/1ps
module pcc_pll_tap
   import pcc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Reference phase from the accumulator
   input wire logic run,
   input wire logic wrap,
   input wire logic [31:0] phase,
   input wire logic [PCC_TAP_W-1:0] tap_sel,
   // Divided output
   output logic pll_output
);
   logic [PCC_WRAP_W-1:0] wrap_cnt_r;
   logic [7:0] ext_phase;
   logic [2:0] bit_idx;

   // Wrap count extends the phase so taps below the reference rate exist
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wrap_cnt_r <= '0;
      end else if (run && wrap) begin
         wrap_cnt_r <= wrap_cnt_r + 1'b1;
      end
   end

   // VCO sits 4 bits below the reference bit; tap 7 reads it directly
   assign ext_phase = {wrap_cnt_r, phase[31:32-PCC_VCO_MULT_LOG2-1]};
   assign bit_idx = 3'h7 - tap_sel;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pll_output <= 1'b0;
      end else begin
         pll_output <= run & ext_phase[bit_idx];
      end
   end
endmodule

// ### design/pcc_counter_unit.sv
// Two per-core counter modules with phase accumulators and pin logic
`timescale 1ns/1ps
module pcc_counter_unit
   import pcc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Core register writes
   input wire logic wr_en,
   input wire logic wr_unit,
   input wire logic [1:0] wr_sel,
   input wire logic [31:0] wr_data,
   // Core register reads
   input wire logic rd_en,
   input wire logic rd_unit,
   input wire logic [1:0] rd_sel,
   input wire logic rd_src,
   output logic [31:0] rd_data,
   // Pins and the core's direction bits
   input wire logic [PCC_PINS-1:0] pin_in,
   input wire logic [PCC_PINS-1:0] pin_dir,
   output logic [PCC_PINS-1:0] pin_drive,
   // PLL outputs, first unit feeds the video timing
   output logic [PCC_UNITS-1:0] pll_output
);
   // Pin input synchroniser and agreement filter
   logic [PCC_PINS-1:0] sync1_r;
   logic [PCC_PINS-1:0] sync2_r;
   logic [PCC_PINS-1:0] sync3_r;
   logic [PCC_PINS-1:0] pin_filt_r;
   logic [PCC_PINS-1:0] agree;

   // Per-unit registers
   logic [31:0] ctrl_r [PCC_UNITS];
   logic [31:0] incr_r [PCC_UNITS];
   logic [31:0] phase_r [PCC_UNITS];
   logic [31:0] shadow_r [PCC_UNITS];
   logic [PCC_UNITS-1:0] a_d1_r;
   logic [PCC_UNITS-1:0] a_d2_r;
   logic [PCC_UNITS-1:0] b_d1_r;

   // Per-unit combinational results
   logic [PCC_PINS-1:0] unit_pins [PCC_UNITS];
   logic [PCC_UNITS-1:0] acc_en;
   logic [PCC_UNITS-1:0] pll_run;
   logic [PCC_UNITS-1:0] carry;
   logic [31:0] sum [PCC_UNITS];

   // Synchroniser: first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
      end else begin
         sync1_r <= pin_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // A pin change counts once the last two stages agree
   assign agree = ~(sync2_r ^ sync3_r);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_filt_r <= '0;
      end else begin
         pin_filt_r <= (sync2_r & agree) | (pin_filt_r & ~agree);
      end
   end

   genvar u;
   generate
      for (u = 0; u < PCC_UNITS; u++) begin : g_unit
         logic hit;
         logic [4:0] mode;
         logic [PCC_TAP_W-1:0] tap;
         logic [PCC_PIN_W-1:0] primary_pin_select;
         logic [PCC_PIN_W-1:0] secondary_pin_select;
         logic a1;
         logic a2;
         logic b1;
         logic acc;
         logic a_out;
         logic b_out;
         logic pll_q;

         assign hit = wr_en && (wr_unit == u[0]);
         // Field extraction of the control word
         assign mode = ctrl_r[u][PCC_MODE_LSB +: PCC_MODE_W];
         assign tap = ctrl_r[u][PCC_TAP_LSB +: PCC_TAP_W];
         assign primary_pin_select = ctrl_r[u][PCC_PRIMARY_PIN_SELECT_LSB +: PCC_PIN_W];
         assign secondary_pin_select = ctrl_r[u][PCC_SECONDARY_PIN_SELECT_LSB +: PCC_PIN_W];
         assign a1 = a_d1_r[u];
         assign a2 = a_d2_r[u];
         assign b1 = b_d1_r[u];

         // Control register, live on the next cycle after the write
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               ctrl_r[u] <= PCC_CTRL_RST;
            end else if (hit && wr_sel == PCC_SEL_CTRL) begin
               ctrl_r[u] <= wr_data;
            end
         end

         always_ff @(posedge clk_sys) begin
            if (rst) begin
               incr_r[u] <= PCC_INCR_RST;
            end else if (hit && wr_sel == PCC_SEL_INCR) begin
               incr_r[u] <= wr_data;
            end
         end

         // Carry of the phase addition drives the duty modes
         assign {carry[u], sum[u]} = {1'b0, phase_r[u]} + {1'b0, incr_r[u]};

         // Phase accumulator; a core write wins over the sum
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               phase_r[u] <= PCC_PHASE_RST;
            end else if (hit && wr_sel == PCC_SEL_PHASE) begin
               phase_r[u] <= wr_data;
            end else if (acc) begin
               phase_r[u] <= sum[u];
            end
         end

         // Last core-written phase, seen by destination reads
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               shadow_r[u] <= PCC_PHASE_RST;
            end else if (hit && wr_sel == PCC_SEL_PHASE) begin
               shadow_r[u] <= wr_data;
            end
         end

         // Primary delayed once and twice, secondary once
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               a_d1_r[u] <= 1'b0;
               a_d2_r[u] <= 1'b0;
               b_d1_r[u] <= 1'b0;
            end else begin
               a_d1_r[u] <= pin_filt_r[primary_pin_select];
               a_d2_r[u] <= a_d1_r[u];
               b_d1_r[u] <= pin_filt_r[secondary_pin_select];
            end
         end

         // Mode decode: accumulate condition and pin outputs
         always_comb begin
            acc = 1'b0;
            a_out = 1'b0;
            b_out = 1'b0;
            if (mode[4]) begin
               // Low four bits are a truth table indexed by the inputs
               acc = mode[{b1, a1}];
            end else begin
               case (mode)
                  PCC_M_OFF: begin
                     acc = 1'b0;
                  end
                  PCC_M_PLL_INT: begin
                     acc = 1'b1;
                  end
                  PCC_M_PLL_SE: begin
                     acc = 1'b1;
                     a_out = pll_q;
                  end
                  PCC_M_PLL_DIFF: begin
                     acc = 1'b1;
                     a_out = pll_q;
                     b_out = ~pll_q;
                  end
                  PCC_M_NCO_SE: begin
                     acc = 1'b1;
                     a_out = phase_r[u][31];
                  end
                  PCC_M_NCO_DIFF: begin
                     acc = 1'b1;
                     a_out = phase_r[u][31];
                     b_out = ~phase_r[u][31];
                  end
                  PCC_M_DUTY_SE: begin
                     acc = 1'b1;
                     a_out = carry[u];
                  end
                  PCC_M_DUTY_DIFF: begin
                     acc = 1'b1;
                     a_out = carry[u];
                     b_out = ~carry[u];
                  end
                  PCC_M_POS: begin
                     acc = a1;
                  end
                  PCC_M_POS_FB: begin
                     acc = a1;
                     b_out = ~a1;
                  end
                  PCC_M_POSEDGE: begin
                     acc = a1 & ~a2;
                  end
                  PCC_M_POSEDGE_FB: begin
                     acc = a1 & ~a2;
                     b_out = ~a1;
                  end
                  PCC_M_NEG: begin
                     acc = ~a1;
                  end
                  PCC_M_NEG_FB: begin
                     acc = ~a1;
                     b_out = ~a1;
                  end
                  PCC_M_NEGEDGE: begin
                     acc = ~a1 & a2;
                  end
                  PCC_M_NEGEDGE_FB: begin
                     acc = ~a1 & a2;
                     b_out = ~a1;
                  end
                  default: begin
                     acc = 1'b0;
                  end
               endcase
            end
         end

         assign acc_en[u] = acc;
         assign pll_run[u] = (mode == PCC_M_PLL_INT) || (mode == PCC_M_PLL_SE)
            || (mode == PCC_M_PLL_DIFF);

         // Place the two outputs on their selected pins
         always_comb begin
            unit_pins[u] = '0;
            unit_pins[u][primary_pin_select] = a_out;
            unit_pins[u][secondary_pin_select] = unit_pins[u][secondary_pin_select] | b_out;
         end

         // Phase bit 31 is the reference
         pcc_pll_tap u_pll (
            .clk_sys(clk_sys),
            .rst(rst),
            .run(pll_run[u]),
            .wrap(carry[u] & acc_en[u]),
            .phase(phase_r[u]),
            .tap_sel(tap),
            .pll_output(pll_q)
         );

         assign pll_output[u] = pll_q;
      end
   endgenerate

   // Direction bits gate the combined counter outputs onto the pins
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_drive <= '0;
      end else begin
         pin_drive <= (unit_pins[0] | unit_pins[1]) & pin_dir;
      end
   end

   // Read port: source operand sees the live phase, destination the shadow
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_data <= '0;
      end else if (rd_en) begin
         unique case (rd_sel)
            PCC_SEL_CTRL: begin
               rd_data <= ctrl_r[rd_unit];
            end
            PCC_SEL_INCR: begin
               rd_data <= incr_r[rd_unit];
            end
            PCC_SEL_PHASE: begin
               rd_data <= rd_src ? phase_r[rd_unit] : shadow_r[rd_unit];
            end
            default: begin
               rd_data <= '0;
            end
         endcase
      end
   end
endmodule

// ### sim/pcc_counter_props.sv
// Port-level assertion checker for the per-core counter unit
`timescale 1ns/1ps
module pcc_counter_props
   import pcc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Register bus
   input wire logic wr_en,
   input wire logic wr_unit,
   input wire logic [1:0] wr_sel,
   input wire logic [31:0] wr_data,
   input wire logic rd_en,
   input wire logic rd_unit,
   input wire logic [1:0] rd_sel,
   input wire logic rd_src,
   input wire logic [31:0] rd_data,
   // Pins
   input wire logic [PCC_PINS-1:0] pin_in,
   input wire logic [PCC_PINS-1:0] pin_dir,
   input wire logic [PCC_PINS-1:0] pin_drive,
   input wire logic [PCC_UNITS-1:0] pll_output
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Shadows of what the core last wrote; selector 3 is dropped like the design
   logic [31:0] ctl_r [2];
   logic [31:0] inc_r [2];
   logic [31:0] phw_r [2];
   logic [31:0] pick;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < 2; i++) begin
            ctl_r[i] <= PCC_CTRL_RST;
            inc_r[i] <= PCC_INCR_RST;
            phw_r[i] <= PCC_PHASE_RST;
         end
      end else if (wr_en) begin
         case (wr_sel)
            PCC_SEL_CTRL: ctl_r[wr_unit] <= wr_data;
            PCC_SEL_INCR: inc_r[wr_unit] <= wr_data;
            PCC_SEL_PHASE: phw_r[wr_unit] <= wr_data;
            default: ;
         endcase
      end
   end
   always_comb begin
      case (rd_sel)
         PCC_SEL_CTRL: pick = ctl_r[rd_unit];
         PCC_SEL_INCR: pick = inc_r[rd_unit];
         default: pick = phw_r[rd_unit];
      endcase
   end
   sequence s_ph_wr;
      wr_en && wr_sel == PCC_SEL_PHASE;
   endsequence
   sequence s_live_rd;
      rd_en && !wr_en && rd_sel == PCC_SEL_PHASE && rd_src && rd_unit == $past(wr_unit);
   endsequence
   property p_reset_quiet;
      $fell(rst) |-> pin_drive == '0 && pll_output == '0 && rd_data == '0;
   endproperty
   property p_dir_mask;
      $stable(pin_dir) |-> (pin_drive & ~pin_dir) == '0;
   endproperty
   property p_rd3;
      rd_en && rd_sel == 2'h3 |=> rd_data == '0;
   endproperty
   property p_rd_hold;
      !rd_en |=> $stable(rd_data);
   endproperty
   property p_rd_regs;
      rd_en && !wr_en && rd_sel != PCC_SEL_PHASE && rd_sel != 2'h3 |=> rd_data == $past(pick);
   endproperty
   property p_rd_dest;
      rd_en && !wr_en && rd_sel == PCC_SEL_PHASE && !rd_src |=> rd_data == $past(pick);
   endproperty
   property p_live;
      s_ph_wr ##1 s_live_rd |=> rd_data == $past(wr_data, 2);
   endproperty
   property p_off;
      (ctl_r[0] == '0 && ctl_r[1] == '0) [*3] |-> pin_drive == '0;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle after reset");
   a_dir_mask: assert property (p_dir_mask) else $error("drive on an input pin");
   a_rd3: assert property (p_rd3) else $error("unused selector read not zero");
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without request");
   a_rd_regs: assert property (p_rd_regs) else $error("control or increment readback");
   a_rd_dest: assert property (p_rd_dest) else $error("destination phase read");
   a_live: assert property (p_live) else $error("live phase after write");
   a_off: assert property (p_off) else $error("pins driven while both counters off");
endmodule

bind pcc_counter_unit pcc_counter_props pcc_counter_props_inst (.clk_sys(clk_sys), .rst(rst),
   .wr_en(wr_en), .wr_unit(wr_unit), .wr_sel(wr_sel), .wr_data(wr_data), .rd_en(rd_en),
   .rd_unit(rd_unit), .rd_sel(rd_sel), .rd_src(rd_src), .rd_data(rd_data), .pin_in(pin_in),
   .pin_dir(pin_dir), .pin_drive(pin_drive), .pll_output(pll_output));

// ### sim/pcc_pin_model.sv
// Far-side pin model: outside levels on input pins, own drive read back on outputs
`timescale 1ns/1ps
module pcc_pin_model
   import pcc_pkg::*;
(
   // Outside levels and counter drive
   input wire logic [PCC_PINS-1:0] ext_level,
   input wire logic [PCC_PINS-1:0] pin_dir,
   input wire logic [PCC_PINS-1:0] pin_drive,
   // Pad levels seen by the counters
   output logic [PCC_PINS-1:0] pin_in
);
   assign pin_in = (pin_drive & pin_dir) | (ext_level & ~pin_dir);
endmodule

// ### sim/tb.sv
// Self-checking bench for the per-core counter unit
`timescale 1ns/1ps
module tb;
   import pcc_pkg::*;
   typedef struct {logic u; logic [1:0] s; logic [31:0] d; logic [31:0] e;} pcc_row_s;
   logic clk_sys, rst, wr_en, wr_unit, rd_en, rd_unit, rd_src, p1;
   logic [1:0] wr_sel, rd_sel;
   logic [1:0] pll_output;
   logic [31:0] wr_data, rd_data, v, w, pin_in, pin_dir, pin_drive, ext_level;
   logic [4:0] m;
   int bad_count = 0;
   int check_count = 0;
   pcc_row_s rows [5] = '{'{0, PCC_SEL_INCR, 32'h1234_5678, 32'h1234_5678},
      '{1, PCC_SEL_INCR, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
      '{1, PCC_SEL_CTRL, 32'h4000_0000, 32'h4000_0000},
      '{0, PCC_SEL_PHASE, 32'hA5A5_0001, 32'hA5A5_0001},
      '{0, 2'h3, 32'hDEAD_BEEF, 32'h0000_0000}};
   pcc_counter_unit pcc_counter_unit_inst (.clk_sys(clk_sys), .rst(rst), .wr_en(wr_en),
      .wr_unit(wr_unit), .wr_sel(wr_sel), .wr_data(wr_data), .rd_en(rd_en), .rd_unit(rd_unit),
      .rd_sel(rd_sel), .rd_src(rd_src), .rd_data(rd_data), .pin_in(pin_in), .pin_dir(pin_dir),
      .pin_drive(pin_drive), .pll_output(pll_output));
   pcc_pin_model pcc_pin_model_inst (.ext_level(ext_level), .pin_dir(pin_dir),
      .pin_drive(pin_drive), .pin_in(pin_in));
   task automatic wr(input logic u, input logic [1:0] s, input logic [31:0] d);
      wr_unit <= u;
      wr_sel <= s;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic u, input logic [1:0] s, input logic src, output logic [31:0] q);
      rd_unit <= u;
      rd_sel <= s;
      rd_src <= src;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      @(posedge clk_sys);
      q = rd_data;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h got %h", n, e, g);
      end
   endtask
   // Primary pin 3, secondary pin 7, tap 0
   function automatic logic [31:0] ctl(input logic [4:0] md);
      return (32'(md) << PCC_MODE_LSB) | (32'd7 << PCC_SECONDARY_PIN_SELECT_LSB) | 32'd3;
   endfunction
   task automatic wrap_up();
      if (bad_count == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      wrap_up();
   end
   initial begin
      {rst, wr_en, wr_unit, rd_en, rd_unit, rd_src} = 6'b10_0000;
      {wr_sel, rd_sel, wr_data, pin_dir, ext_level} = '0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd(i[0], 2'(i / 2), 1'b0, v);
         chk("reset value", 32'h0000_0000, v);
      end
      foreach (rows[i]) begin
         wr(rows[i].u, rows[i].s, rows[i].d);
         rd(rows[i].u, rows[i].s, 1'b0, v);
         chk("register row", rows[i].e, v);
      end
      // Steady A high, B low: only the always-count, positive level and logic modes with bit 1 set may add
      ext_level[3] <= 1'b1;
      wr(0, PCC_SEL_INCR, 32'h0000_0001);
      for (int i = 0; i < 32; i++) begin
         m = 5'(i);
         wr(0, PCC_SEL_PHASE, 32'h0000_0000);
         wr(0, PCC_SEL_CTRL, ctl(m));
         repeat (6) @(posedge clk_sys);
         // Stop with mode 0 but keep the pin fields, so the delayed inputs stay on pin 3
         wr(0, PCC_SEL_CTRL, ctl(5'h00));
         rd(0, PCC_SEL_PHASE, 1'b1, v);
         p1 = (m >= 5'h01 && m <= 5'h09) || (m[4] && m[1]);
         chk("mode count", {31'b0, p1}, {31'b0, |v});
      end
      // One edge gives exactly one addition
      for (int j = 0; j < 2; j++) begin
         ext_level[3] <= j[0];
         repeat (8) @(posedge clk_sys);
         wr(0, PCC_SEL_PHASE, 32'h0000_0000);
         wr(0, PCC_SEL_CTRL, ctl(j ? PCC_M_NEGEDGE : PCC_M_POSEDGE));
         repeat (4) @(posedge clk_sys);
         ext_level[3] <= ~j[0];
         repeat (10) @(posedge clk_sys);
         wr(0, PCC_SEL_CTRL, 32'h0000_0000);
         rd(0, PCC_SEL_PHASE, 1'b1, v);
         chk("edge count", 32'h0000_0001, v);
      end
      pin_dir <= 32'h0000_0080;
      wr(1, PCC_SEL_CTRL, ctl(PCC_M_POS_FB));
      for (int j = 0; j < 2; j++) begin
         ext_level[3] <= j[0];
         repeat (10) @(posedge clk_sys);
         chk("feedback pin", {31'b0, ~j[0]}, {31'b0, pin_drive[7]});
      end
      pin_dir <= 32'h0000_0000;
      repeat (3) @(posedge clk_sys);
      chk("masked pin", 32'h0000_0000, pin_drive);
      // Oscillator on pins 1 and 2, bit 31 flips every cycle
      pin_dir <= 32'h0000_0006;
      wr(1, PCC_SEL_INCR, 32'h8000_0000);
      wr(1, PCC_SEL_CTRL, (32'(PCC_M_NCO_DIFF) << PCC_MODE_LSB) | (32'd2 << PCC_SECONDARY_PIN_SELECT_LSB) | 32'd1);
      repeat (4) @(negedge clk_sys);
      v = pin_drive;
      @(negedge clk_sys);
      chk("nco diff", {31'b0, ~v[1]}, {31'b0, v[2]});
      chk("nco toggle", {31'b0, ~v[1]}, {31'b0, pin_drive[1]});
      @(posedge clk_sys);
      wr(1, PCC_SEL_CTRL, 32'h0000_0000);
      repeat (3) @(posedge clk_sys);
      chk("off pins", 32'h0000_0000, pin_drive);
      rd(1, PCC_SEL_PHASE, 1'b1, v);
      repeat (4) @(posedge clk_sys);
      rd(1, PCC_SEL_PHASE, 1'b1, w);
      chk("off phase", v, w);
      // Reference of 6.25 MHz puts the VCO at 100 MHz, inside the stable band
      wr(1, PCC_SEL_INCR, 32'h0800_0000);
      wr(1, PCC_SEL_CTRL, (32'(PCC_M_PLL_SE) << PCC_MODE_LSB) | (32'd7 << PCC_TAP_LSB));
      repeat (3) @(negedge clk_sys);
      v[0] = pll_output[1];
      @(negedge clk_sys);
      chk("pll tap", {31'b0, ~v[0]}, {31'b0, pll_output[1]});
      // Phase write while accumulating, then live read at the next edge
      wr(1, PCC_SEL_INCR, 32'h0000_0003);
      wr(1, PCC_SEL_CTRL, 32'(PCC_M_NCO_SE) << PCC_MODE_LSB);
      wr_data <= 32'h0000_0100;
      wr_sel <= PCC_SEL_PHASE;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      rd(1, PCC_SEL_PHASE, 1'b1, v);
      chk("phase override", 32'h0000_0100, v);
      rd(1, PCC_SEL_PHASE, 1'b0, v);
      chk("dest read", 32'h0000_0100, v);
      rd(1, PCC_SEL_PHASE, 1'b1, v);
      chk("live moved", 32'h0000_0001, {31'b0, v != 32'h0000_0100});
      wrap_up();
   end
endmodule
